// ### dv/phy_line_model.sv
`timescale 1ns/1ps
module phy_line_model (
  input wire logic hclk,
  input wire logic [1:0] ls_cmd,
  input wire logic [3:0] lag,
  output logic [1:0] linestate_raw
);
  logic [3:0] cnt = 4'h0;
  initial linestate_raw = 2'h1;
  // A slow host puts its symbol on the line lag cycles late
  always @(posedge hclk) begin
    cnt <= (ls_cmd == linestate_raw || cnt == lag) ? 4'h0 : cnt + 4'h1;
    if (cnt == lag && ls_cmd != linestate_raw) linestate_raw <= ls_cmd;
  end
endmodule : phy_line_model

// ### dv/usb_phy_control_regs_monitor.sv
`timescale 1ns/1ps
module usb_phy_control_regs_monitor (
  input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans, linestate_raw, linestate_filt,
  input wire logic [2:0] hsize, transceiver_config_inputs,
  input wire logic [31:0] hwdata, hrdata,
  input wire logic suspend_req, resume_active, suspended,
  input wire logic pulldown_dis_port_a, pulldown_dis_port_b
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire tk = hsel && hready && htrans == 2'h2;
  sequence wr40;
    tk && hwrite && hsize == 3'h2 && haddr == 8'h40;
  endsequence
  sequence rd40;
    tk && !hwrite && haddr == 8'h40;
  endsequence
  ok_resp_a: assert property (hreadyout && !hresp)
    else $error("response not ready okay");
  cfg_copy_a: assert property (wr40 ##1 1 |=>
    transceiver_config_inputs == $past(hwdata[6:4])) else $error("config");
  pd_copy_a: assert property (wr40 ##1 1 |=>
    pulldown_dis_port_a == $past(hwdata[18]) &&
    pulldown_dis_port_b == pulldown_dis_port_a) else $error("pulldown");
  read_back_a: assert property (wr40 ##1 rd40 |=>
    (hrdata & 32'h0004_0FF0) == ($past(hwdata) & 32'h0004_0FF0))
    else $error("read back");
  unmap_read_a: assert property (tk && !hwrite && haddr > 8'h40 |=>
    hrdata == 32'h0) else $error("unmapped read");
  filt_source_a: assert property ($changed(linestate_filt) |->
    $past(linestate_raw) == linestate_filt) else $error("filter");
  sleep_cause_a: assert property ($rose(suspended) |->
    $past(suspend_req)) else $error("sleep");
  wake_cause_a: assert property ($rose(resume_active) |->
    $past(suspended)) else $error("wake");
endmodule : usb_phy_control_regs_monitor
bind usb_phy_control_regs usb_phy_control_regs_monitor mon (.*);

// ### dv/usb_phy_control_regs_tb_top.sv
`timescale 1ns/1ps
module usb_phy_control_regs_tb_top;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic suspend_req = 1'b0, hreadyout, hresp, resume_active, suspended;
  logic pulldown_dis_port_a, pulldown_dis_port_b;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0, ls_cmd = 2'h1, linestate_raw, linestate_filt;
  logic [2:0] hsize = 3'h2, transceiver_config_inputs;
  logic [3:0] lag = 4'h0;
  logic [31:0] hwdata = 32'h0, hrdata, d, q;
  logic [15:0] seed = 16'h0040;
  int failures = 0, n_tests = 0, cyc = 0;
  wire hready = hreadyout;
  usb_phy_control_regs dut (.*);
  phy_line_model phy (.hclk, .ls_cmd, .lag, .linestate_raw);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] rmask(input logic [7:0] a);
    return a == 8'h38 ? 32'hFFFF_FFFF : a == 8'h3C ? 32'h0000_01FF :
      a == 8'h40 ? 32'h0004_3FF0 : 32'h0;
  endfunction : rmask
  task automatic chk(input string n, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test;
    end
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("filt_rst", 32'h1, {30'h0, linestate_filt});
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      d = {seed, lfsr(seed)};
      if (i < 4) bus(1'b0, 8'h38 + {i[3:0], 2'h0}, 32'h0, q);
      if (i < 4) chk("reset", 32'h0, q);
      bus(1'b1, 8'h38 + {i[1:0], 2'h0}, d, q);
      bus(1'b0, 8'h38 + {i[1:0], 2'h0}, 32'h0, q);
      chk("rdback", d & rmask(8'h38 + {i[1:0], 2'h0}), q);
      if (i[1:0] == 2'h2) begin
        chk("config", {29'h0, d[6:4]}, {29'h0, transceiver_config_inputs});
        chk("pd_a", {31'h0, d[18]}, {31'h0, pulldown_dis_port_a});
        chk("pd_b", {31'h0, d[18]}, {31'h0, pulldown_dis_port_b});
      end
    end
    // Filter of 2**3: still old symbol early, new one after the count
    bus(1'b1, 8'h40, 32'h0000_0300, q);
    ls_cmd <= 2'h2;
    repeat (7) @(posedge hclk);
    chk("filt_hold", 32'h1, {30'h0, linestate_filt});
    repeat (6) @(posedge hclk);
    chk("filt_pass", 32'h2, {30'h0, linestate_filt});
    ls_cmd <= 2'h1;
    repeat (12) @(posedge hclk);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 8'h40, 32'h0000_0080, q);
      suspend_req <= 1'b1;
      lag <= k ? 4'h5 : 4'h0;
      repeat (4) @(posedge hclk);
      chk("asleep", 32'h1, {31'h0, suspended});
      ls_cmd <= k ? 2'h0 : 2'h2;
      repeat (24) @(posedge hclk);
      chk("waking", 32'h1, {31'h0, resume_active});
      suspend_req <= 1'b0;
      ls_cmd <= 2'h1;
      repeat (24) @(posedge hclk);
      bus(1'b0, 8'h40, 32'h0, q);
      chk("cause", k ? 32'h2080 : 32'h1080, q);
      bus(1'b1, 8'h40, 32'h0, q);
      bus(1'b0, 8'h40, 32'h0, q);
      chk("cleared", 32'h0, q);
    end
    stop_test;
  end
endmodule : usb_phy_control_regs_tb_top

// ### hw/linestate_filter.sv
`timescale 1ns/1ps
module linestate_filter
  import usb_phy_ctrl_pkg::*;
#(
  parameter int FILT_W = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] ls_in,
  input wire logic [FILT_W-1:0] filt_log2,
  output logic [1:0] ls_out
);
  initial begin
    if (FILT_W < 1 || FILT_W > 4) $error("FILT_W must be 1..4");
  end
  logic [1:0] cand_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] limit;
  wire changed = ls_in != cand_reg;
  // A new value must stand 2**filt cycles before it is passed on
  assign limit = 16'h0001 << filt_log2;
  // Run length saturates so a long idle line never wraps back below the limit
  assign cnt_next = changed ? 16'h0001 :
    (cnt_reg == 16'hFFFF ? cnt_reg : cnt_reg + 16'h0001);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cand_reg <= LS_J;
      cnt_reg <= FILT_RST_COUNT;
      ls_out <= LS_J;
    end else begin
      cand_reg <= ls_in;
      cnt_reg <= cnt_next;
      if (cnt_next >= limit) ls_out <= ls_in;
    end
  end
endmodule : linestate_filter

// ### hw/usb_phy_control_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Word at 0x38 is a full 32-bit read/write mask, reset zero.
// - Word at 0x3C holds 8-bit data and a valid bit above it.
// - Bit 18 of phy control disables pulldowns on both 8-bit ports.
// - Auto-resume on SE0 sets bit 13; software writes zero to clear.
// - Auto-resume on K sets bit 12; software writes zero to clear.
// - Linestate changes are delayed by 2**filter + 1 clock cycles.
// - Bit 7 lets the suspend controller resume; else software polls.
// - Field 6:4 drives the three transceiver config inputs.
module usb_phy_control_regs
  import usb_phy_ctrl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] linestate_raw,
  input wire logic suspend_req,
  output logic [1:0] linestate_filt,
  output logic resume_active,
  output logic suspended,
  output logic pulldown_dis_port_a,
  output logic pulldown_dis_port_b,
  output logic [2:0] transceiver_config_inputs
);
  logic [31:0] otg_flag_mask_reg;
  logic [8:0] power_signal_word_reg;
  logic [31:0] phy_control_reg;
  logic [31:0] phy_control_next;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  susp_state_t state_reg;
  susp_state_t state_next;
  logic [1:0] ls_f;
  logic set_k;
  logic set_se0;
  wire addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
  wire wr_otg = wr_pend_reg && wr_addr_reg == OFS_OTG_FLAG_MASK;
  wire wr_pwr = wr_pend_reg && wr_addr_reg == OFS_POWER_SIGNAL_WORD;
  wire wr_phy = wr_pend_reg && wr_addr_reg == OFS_PHY_CONTROL;
  // Forward a write in its data phase so a back-to-back read sees it
  wire [31:0] otg_fwd = wr_otg ? hwdata : otg_flag_mask_reg;
  wire [8:0] pwr_fwd = wr_pwr ? hwdata[8:0] : power_signal_word_reg;
  wire [31:0] rd_mux =
    haddr == OFS_OTG_FLAG_MASK ? otg_fwd :
    haddr == OFS_POWER_SIGNAL_WORD ? {23'h000000, pwr_fwd} :
    haddr == OFS_PHY_CONTROL ? phy_control_next : 32'h0000_0000;
  wire susp_en = phy_control_reg[PHY_SUSP_EN_BIT];
  linestate_filter #(.FILT_W(PHY_FILT_W)) u_filt (
    .hclk(hclk),
    .hresetn(hresetn),
    .ls_in(linestate_raw),
    .filt_log2(phy_control_reg[PHY_FILT_LSB +: PHY_FILT_W]),
    .ls_out(ls_f)
  );
  // Suspend controller only wakes the link when software enabled it
  always_comb begin
    state_next = state_reg;
    set_k = 1'b0;
    set_se0 = 1'b0;
    case (state_reg)
      SUSP_IDLE: begin
        if (suspend_req && susp_en) state_next = SUSP_ASLEEP;
      end
      SUSP_ASLEEP: begin
        if (!susp_en) begin
          state_next = SUSP_IDLE;
        end else if (ls_f == LS_K) begin
          state_next = SUSP_WAKE;
          set_k = 1'b1;
        end else if (ls_f == LS_SE0) begin
          state_next = SUSP_WAKE;
          set_se0 = 1'b1;
        end
      end
      SUSP_WAKE: begin
        if (ls_f == LS_J || !suspend_req) state_next = SUSP_IDLE;
      end
      default: state_next = SUSP_IDLE;
    endcase
  end
  // Hardware set beats a software clear in the same cycle
  always_comb begin
    phy_control_next = phy_control_reg;
    if (wr_phy) phy_control_next = hwdata & PHY_CONTROL_RW_MASK;
    if (set_k) phy_control_next[PHY_RESUME_K_BIT] = 1'b1;
    if (set_se0) phy_control_next[PHY_RESUME_SE0_BIT] = 1'b1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite && hsize == HSIZE_WORD;
      wr_addr_reg <= haddr;
      if (addr_ok && !hwrite) hrdata <= rd_mux;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      otg_flag_mask_reg <= RST_OTG_FLAG_MASK;
      power_signal_word_reg <= RST_POWER_SIGNAL_WORD;
      phy_control_reg <= RST_PHY_CONTROL;
      state_reg <= SUSP_IDLE;
    end else begin
      if (wr_otg) otg_flag_mask_reg <= hwdata;
      if (wr_pwr) power_signal_word_reg <= hwdata[8:0];
      phy_control_reg <= phy_control_next;
      state_reg <= state_next;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      linestate_filt <= LS_J;
      resume_active <= 1'b0;
      suspended <= 1'b0;
      pulldown_dis_port_a <= 1'b0;
      pulldown_dis_port_b <= 1'b0;
      transceiver_config_inputs <= 3'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      linestate_filt <= ls_f;
      resume_active <= state_next == SUSP_WAKE;
      suspended <= state_next == SUSP_ASLEEP;
      pulldown_dis_port_a <= phy_control_next[PHY_PULLDOWN_DIS_BIT];
      pulldown_dis_port_b <= phy_control_next[PHY_PULLDOWN_DIS_BIT];
      transceiver_config_inputs <=
        phy_control_next[PHY_CONF_LSB +: PHY_CONF_W];
    end
  end
endmodule : usb_phy_control_regs

// ### hw/usb_phy_ctrl_pkg.sv
package usb_phy_ctrl_pkg;
  localparam logic [7:0] OFS_OTG_FLAG_MASK = 8'h38;
  localparam logic [7:0] OFS_POWER_SIGNAL_WORD = 8'h3C;
  localparam logic [7:0] OFS_PHY_CONTROL = 8'h40;
  localparam logic [31:0] RST_OTG_FLAG_MASK = 32'h0000_0000;
  localparam logic [8:0] RST_POWER_SIGNAL_WORD = 9'h000;
  localparam logic [31:0] RST_PHY_CONTROL = 32'h0000_0000;
  localparam int PWR_DATA_LSB = 0;
  localparam int PWR_DATA_W = 8;
  localparam int PWR_VALID_BIT = 8;
  localparam int PHY_CONF_LSB = 4;
  localparam int PHY_CONF_W = 3;
  localparam int PHY_SUSP_EN_BIT = 7;
  localparam int PHY_FILT_LSB = 8;
  localparam int PHY_FILT_W = 4;
  localparam int PHY_RESUME_K_BIT = 12;
  localparam int PHY_RESUME_SE0_BIT = 13;
  localparam int PHY_PULLDOWN_DIS_BIT = 18;
  localparam logic [31:0] PHY_CONTROL_RW_MASK = 32'h0004_3FF0;
  localparam logic [31:0] POWER_RW_MASK = 32'h0000_01FF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [15:0] FILT_RST_COUNT = 16'h0000;
  typedef enum logic [2:0] {
    SUSP_IDLE = 3'b001,
    SUSP_ASLEEP = 3'b010,
    SUSP_WAKE = 3'b100
  } susp_state_t;
endpackage : usb_phy_ctrl_pkg
